// file: rtl/fep_pkg.sv
// Constants shared by the fast ethernet coding block
package fep_pkg;
    // ****************************************
    // Code groups
    // ****************************************
    localparam logic [4:0] SYM_IDLE = 5'h1f;  // All-ones fill
    localparam logic [4:0] SYM_J    = 5'h18;  // Start pair, first
    localparam logic [4:0] SYM_K    = 5'h11;  // Start pair, second
    localparam logic [4:0] SYM_T    = 5'h0d;  // End pair, first
    localparam logic [4:0] SYM_R    = 5'h07;  // End pair, second
    localparam logic [4:0] SYM_H    = 5'h04;  // Forced error group
    localparam logic [3:0] NIB_PRE  = 4'h5;   // Preamble nibble
    localparam logic [3:0] NIB_ZERO = 4'h0;   // Quiet data lines
    localparam logic [3:0] NIB_ONES = 4'hf;   // Padding ones
    localparam logic [2:0] TAIL_FULL = 3'h4;  // Trailing bits forming a nibble
    localparam logic [2:0] TAIL_NONE = 3'h0;  // No trailing bits
    // ****************************************
    // Scrambler
    // ****************************************
    localparam int         LFSR_W   = 11;     // Scrambler length
    localparam int         TAP_HI   = 10;     // Feedback taps
    localparam int         TAP_LO   = 8;
    localparam logic [5:0] SEED_HI  = 6'h2a;  // Fixed upper seed bits
    localparam logic [4:0] KEY_OFF  = 5'h00;  // Bypassed key stream
    localparam logic [3:0] LOCK_RUN = 4'hc;   // Idle groups for lock
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_KHZ  = 40000;            // 40 MHz clock
    localparam int LINK_MS  = 50;               // Lock hold before link up
    localparam int WIN_MS   = 2;                // Lock check window
    localparam int LINK_CYC = LINK_MS * CLK_KHZ;
    localparam int WIN_CYC  = WIN_MS * CLK_KHZ;
    localparam int CNT_W    = 21;               // Fits both counts
    // ****************************************
    // Registers
    // ****************************************
    localparam int         AW       = 4;      // Address width
    localparam int         DW       = 16;     // Data width
    localparam logic [3:0] REG_CTRL = 4'h0;   // Control
    localparam logic [3:0] REG_STAT = 4'h4;   // Status
    localparam int CTL_BYP = 0;               // Scrambler bypass
    localparam int CTL_OVR = 1;               // Transmit with link down
    localparam int CTL_ANE = 2;               // Auto-negotiation enabled
    localparam int CTL_FIB = 3;               // Fiber port selected
    localparam logic [3:0] CTRL_RST = 4'h4;   // Negotiation on at reset
    localparam int STA_LL  = 0;               // Link, latched low
    localparam int STA_LNK = 1;               // Link, live
    localparam int STA_LCK = 2;               // Descrambler locked
    localparam int STA_CRS = 3;               // Carrier sense
    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_J    = 2'b01,
        TX_DATA = 2'b11,
        TX_T    = 2'b10
    } fep_tx_e;
    typedef enum logic [0:0] {
        RX_IDLE  = 1'b0,
        RX_FRAME = 1'b1
    } fep_rx_e;
endpackage

// file: rtl/fep_coding.sv
// 100 Mbps 4B/5B coding, scrambling, link monitor and carrier sense
// Notes on behaviour
// - one to four trailing bits: deliver, pad ones
// - five to seven trailing bits: drop second nibble
// - fixed nibble codes; undefined codes are invalid
// - send idle groups between frames
// - start pair J then K together
// - end pair T then R together
// - transmit error sends the H group
// - link up after lock held 50 ms
// - under 12 idles per 2 ms drops lock
// - 100 Mbps idles never raise 10 Mbps link
// - link loss shows in status, restarts negotiation
// - send data only with link, or override with negotiation off
// - negotiation on, link down: send link pulses
// - J-K pair raises carrier sense
// - T-R pair drops carrier sense
// - idle without T-R: drop carrier, one error
// - data valid marks symbols; data zero until ready
// - 11-bit scrambler; receiver locks from idles
// - seed takes five bits from address
// - bypass scrambler by control or fiber
// - first two nibbles become J-K pair
// - received J-K becomes two preamble nibbles
// - idle groups while transmit enable low
// - invalid group raises receive error
module fep_coding #(
    parameter int unsigned P_LINK_CYC = fep_pkg::LINK_CYC,  // Lock hold
    parameter int unsigned P_WIN_CYC  = fep_pkg::WIN_CYC    // Lock window
) (
    input  wire logic                   I_CLOCK,
    input  wire logic                   I_RESET_N,
    input  wire logic                   I_CLK_EN,
    input  wire logic [fep_pkg::AW-1:0] I_ADDR,
    input  wire logic [fep_pkg::DW-1:0] I_WDATA,
    input  wire logic                   I_WRITE,
    input  wire logic                   I_READ,
    output logic      [fep_pkg::DW-1:0] O_RDATA,
    input  wire logic [4:0]             I_PHY_ADDR,
    input  wire logic                   I_SPEED_100,
    input  wire logic                   I_TX_STB,
    input  wire logic                   I_TX_EN,
    input  wire logic                   I_TX_ER,
    input  wire logic [3:0]             I_TXD,
    output logic      [4:0]             O_TX_SYM,
    input  wire logic                   I_RX_STB,
    input  wire logic [4:0]             I_RX_SYM,
    input  wire logic [2:0]             I_RX_TAIL_CNT,
    input  wire logic [3:0]             I_RX_TAIL_NIB,
    output logic      [3:0]             O_RXD,
    output logic                        O_RX_DV,
    output logic                        O_RX_ER,
    output logic                        O_CRS,
    output logic                        O_LINK_UP,
    output logic                        O_FLP_SEL,
    output logic                        O_AN_RESTART
);
    import fep_pkg::*;

    // ****************************************
    // Coding functions
    // ****************************************
    // Nibble to code group
    function automatic logic [4:0] enc4(input logic [3:0] n);
        case (n)
            4'h0: enc4 = 5'h1e;
            4'h1: enc4 = 5'h09;
            4'h2: enc4 = 5'h14;
            4'h3: enc4 = 5'h15;
            4'h4: enc4 = 5'h0a;
            4'h5: enc4 = 5'h0b;
            4'h6: enc4 = 5'h0e;
            4'h7: enc4 = 5'h0f;
            4'h8: enc4 = 5'h12;
            4'h9: enc4 = 5'h13;
            4'ha: enc4 = 5'h16;
            4'hb: enc4 = 5'h17;
            4'hc: enc4 = 5'h1a;
            4'hd: enc4 = 5'h1b;
            4'he: enc4 = 5'h1c;
            default: enc4 = 5'h1d;
        endcase
    endfunction

    // Code group to {valid, nibble}; all other groups invalid
    function automatic logic [4:0] dec5(input logic [4:0] s);
        dec5 = {1'b0, NIB_ZERO};
        for (int i = 0; i < 16; i++) begin
            if (enc4(4'(i)) == s) begin
                dec5 = {1'b1, 4'(i)};
            end
        end
    endfunction

    // Five scrambler steps; acquire loads observed key bits
    function automatic logic [15:0] scr5(input logic [10:0] s, input logic [4:0] o, input logic acq);
        logic [10:0] st;
        logic [4:0]  k;
        st = s;
        k  = KEY_OFF;
        for (int i = 4; i >= 0; i--) begin
            k[i] = st[TAP_HI] ^ st[TAP_LO];
            st   = {st[9:0], acq ? o[i] : k[i]};
        end
        scr5 = {st, k};
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic            seeded;   // Seed taken after reset
        logic [3:0]      ctrl;     // Control register
        logic [DW-1:0]   rdata;    // Read answer
        logic            ll;       // Latched-low link status
        logic            link;     // Link up
        logic [CNT_W-1:0] up_cnt;  // Lock hold counter
        logic            flp;      // Link pulses instead of data
        logic            anr;      // Negotiation restart pulse
        fep_tx_e         tx_st;    // Transmit sequence
        logic [10:0]     tx_lfsr;  // Transmit scrambler
        logic [4:0]      tx_sym;   // Line symbol
        logic [10:0]     rx_lfsr;  // Receive descrambler
        logic            locked;   // Descrambler lock
        logic [3:0]      run;      // Matching idles during acquisition
        logic [3:0]      idle_run; // Consecutive idles while locked
        logic            win_ok;   // Enough idles seen this window
        logic [CNT_W-1:0] win_cnt; // Window counter
        logic [4:0]      prv;      // Previous decoded-side symbol
        fep_rx_e         rx_st;    // Receive sequence
        logic [2:0]      tail_cnt; // Trailing bit count
        logic [3:0]      tail_nib; // Trailing bits
        logic            crs;      // Carrier sense
        logic            dv;       // Receive data valid
        logic            er;       // Receive error
        logic [3:0]      rxd;      // Receive nibble
    } fep_state_s;

    fep_state_s r_reg;   // Registered state
    fep_state_s r_next;  // Next state

    logic        byp;      // Scrambling bypassed
    logic        allowed;  // Data may be sent
    logic [15:0] tx_s;     // Transmit scrambler step
    logic [15:0] rx_s;     // Receive scrambler step
    logic [4:0]  pred;     // Predicted key
    logic [4:0]  d;        // Descrambled symbol
    logic [4:0]  dp;       // Decode of previous symbol
    logic [4:0]  code;     // Unscrambled transmit group
    logic        lock_drop; // Window ends without enough idles

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        r_next  = r_reg;
        byp     = r_reg.ctrl[CTL_BYP] | r_reg.ctrl[CTL_FIB];
        allowed = r_reg.link | (r_reg.ctrl[CTL_OVR] & ~r_reg.ctrl[CTL_ANE]);
        tx_s    = scr5(r_reg.tx_lfsr, KEY_OFF, 1'b0);
        rx_s    = scr5(r_reg.rx_lfsr, I_RX_SYM ^ SYM_IDLE, ~r_reg.locked);
        pred    = byp ? KEY_OFF : rx_s[4:0];
        d       = I_RX_SYM ^ pred;
        dp      = dec5(r_reg.prv);
        code    = SYM_IDLE;
        // Lock loss takes link down in the same cycle, not one later
        lock_drop = r_reg.locked && !r_reg.win_ok && (r_reg.win_cnt == CNT_W'(P_WIN_CYC - 1));
        r_next.anr = 1'b0;

        // Seed catch at first enabled edge after reset
        if (!r_reg.seeded) begin
            r_next.seeded  = 1'b1;
            r_next.tx_lfsr = {SEED_HI, I_PHY_ADDR};
        end

        // Register writes and reads
        if (I_WRITE && I_ADDR == REG_CTRL) begin
            r_next.ctrl = I_WDATA[3:0];
        end
        r_next.rdata = '0;
        if (I_READ) begin
            case (I_ADDR)
                REG_CTRL: r_next.rdata = DW'(r_reg.ctrl);
                REG_STAT: r_next.rdata = DW'({r_reg.crs, r_reg.locked, r_reg.link, r_reg.ll});
                default:  r_next.rdata = '0;
            endcase
            if (I_ADDR == REG_STAT) begin
                r_next.ll = r_reg.link;
            end
        end

        // Link monitor, 100 Mbps only
        if (r_reg.locked && !lock_drop && I_SPEED_100) begin
            if (!r_reg.link) begin
                r_next.up_cnt = r_reg.up_cnt + 1'b1;
                if (r_reg.up_cnt == CNT_W'(P_LINK_CYC - 1)) begin
                    r_next.link = 1'b1;
                end
            end
        end else begin
            r_next.up_cnt = '0;
            r_next.link   = 1'b0;
            if (r_reg.link) begin
                r_next.ll  = 1'b0;
                r_next.anr = r_reg.ctrl[CTL_ANE];
            end
        end
        r_next.flp = r_reg.ctrl[CTL_ANE] & ~r_reg.link;

        // Lock window while locked
        if (r_reg.locked) begin
            r_next.win_cnt = r_reg.win_cnt + 1'b1;
            if (r_reg.win_cnt == CNT_W'(P_WIN_CYC - 1)) begin
                r_next.win_cnt = '0;
                r_next.win_ok  = 1'b0;
                if (!r_reg.win_ok) begin
                    r_next.locked = 1'b0;
                    r_next.run    = '0;
                end
            end
        end else begin
            r_next.win_cnt = '0;
            r_next.win_ok  = 1'b0;
        end

        // Transmit path, one group per strobe
        if (I_TX_STB) begin
            case (r_reg.tx_st)
                TX_IDLE: begin
                    if (I_TX_EN && allowed) begin
                        code = SYM_J;
                        r_next.tx_st = TX_J;
                    end else begin
                        code = SYM_IDLE;
                    end
                end
                TX_J: begin
                    code = SYM_K;
                    r_next.tx_st = TX_DATA;
                end
                TX_DATA: begin
                    if (I_TX_EN) begin
                        code = I_TX_ER ? SYM_H : enc4(I_TXD);
                    end else begin
                        code = SYM_T;
                        r_next.tx_st = TX_T;
                    end
                end
                TX_T: begin
                    code = SYM_R;
                    r_next.tx_st = TX_IDLE;
                end
                default: begin
                    r_next.tx_st = TX_IDLE;
                end
            endcase
            r_next.tx_lfsr = tx_s[15:5];
            r_next.tx_sym  = code ^ (byp ? KEY_OFF : tx_s[4:0]);
        end

        // Receive path, one group per strobe
        if (I_RX_STB) begin
            r_next.rx_lfsr = rx_s[15:5];
            r_next.prv     = d;
            if (!r_reg.locked) begin
                // Acquire the key from idle groups
                if (pred == (I_RX_SYM ^ SYM_IDLE)) begin
                    r_next.run = r_reg.run + 1'b1;
                    if (r_reg.run == LOCK_RUN - 1'b1) begin
                        r_next.locked   = 1'b1;
                        r_next.idle_run = '0;
                    end
                end else begin
                    r_next.run = '0;
                end
            end else if (d == SYM_IDLE) begin
                if (r_reg.idle_run == LOCK_RUN - 1'b1) begin
                    r_next.win_ok = 1'b1;
                end else begin
                    r_next.idle_run = r_reg.idle_run + 1'b1;
                end
            end else begin
                r_next.idle_run = '0;
            end
            if (d == SYM_T) begin
                r_next.tail_cnt = I_RX_TAIL_CNT;
                r_next.tail_nib = I_RX_TAIL_NIB;
            end
            r_next.er = 1'b0;
            case (r_reg.rx_st)
                RX_IDLE: begin
                    r_next.crs = 1'b0;
                    r_next.dv  = 1'b0;
                    r_next.rxd = NIB_ZERO;
                    if (r_reg.locked && r_reg.prv == SYM_J && d == SYM_K) begin
                        r_next.crs   = 1'b1;
                        r_next.dv    = 1'b1;
                        r_next.rxd   = NIB_PRE;
                        r_next.rx_st = RX_FRAME;
                    end
                end
                RX_FRAME: begin
                    if (r_reg.prv == SYM_T && d == SYM_R) begin
                        r_next.crs   = 1'b0;
                        r_next.rx_st = RX_IDLE;
                        r_next.dv    = r_reg.tail_cnt != TAIL_NONE;
                        if (r_reg.tail_cnt == TAIL_NONE) begin
                            r_next.rxd = NIB_ZERO;
                        end else if (r_reg.tail_cnt >= TAIL_FULL) begin
                            r_next.rxd = r_reg.tail_nib;
                        end else begin
                            r_next.rxd = r_reg.tail_nib | (NIB_ONES << r_reg.tail_cnt[1:0]);
                        end
                    end else if (d == SYM_IDLE || !r_reg.locked) begin
                        r_next.crs   = 1'b0;
                        r_next.dv    = 1'b0;
                        r_next.rxd   = NIB_ZERO;
                        r_next.er    = 1'b1;
                        r_next.rx_st = RX_IDLE;
                    end else if (r_reg.prv == SYM_K) begin
                        r_next.dv  = 1'b1;
                        r_next.rxd = NIB_PRE;
                    end else if (dp[4]) begin
                        r_next.dv  = 1'b1;
                        r_next.rxd = dp[3:0];
                    end else begin
                        r_next.dv  = 1'b1;
                        r_next.rxd = NIB_ZERO;
                        r_next.er  = 1'b1;
                    end
                end
                default: begin
                    r_next.rx_st = RX_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            r_reg         <= '0;
            r_reg.ctrl    <= CTRL_RST;
            r_reg.tx_sym  <= SYM_IDLE;
            r_reg.tx_st   <= TX_IDLE;
            r_reg.rx_st   <= RX_IDLE;
        end else if (I_CLK_EN) begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign O_RDATA      = r_reg.rdata;
    assign O_TX_SYM     = r_reg.tx_sym;
    assign O_RXD        = r_reg.rxd;
    assign O_RX_DV      = r_reg.dv;
    assign O_RX_ER      = r_reg.er;
    assign O_CRS        = r_reg.crs;
    assign O_LINK_UP    = r_reg.link;
    assign O_FLP_SEL    = r_reg.flp;
    assign O_AN_RESTART = r_reg.anr;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);

    tx_jk_pair_a: assert property (I_CLK_EN && I_TX_STB && r_reg.tx_st == TX_J |=> r_reg.tx_st == TX_DATA)
        else $error("K did not follow J");
    tx_tr_pair_a: assert property (I_CLK_EN && I_TX_STB && r_reg.tx_st == TX_T |=> r_reg.tx_st == TX_IDLE)
        else $error("R did not follow T");
    tx_gate_a: assert property (I_CLK_EN && I_TX_STB && r_reg.tx_st == TX_IDLE && !allowed |=> r_reg.tx_st == TX_IDLE)
        else $error("frame started without link");
    tx_idle_fill_a: assert property (I_CLK_EN && I_TX_STB && byp && r_reg.tx_st == TX_IDLE && !I_TX_EN
        |=> O_TX_SYM == SYM_IDLE)
        else $error("no idle fill while enable low");
    link_lock_a: assert property (O_LINK_UP |-> r_reg.locked && $past(r_reg.locked))
        else $error("link up without lock");
    link_hold_a: assert property ($rose(O_LINK_UP) |-> $past(r_reg.up_cnt) == CNT_W'(P_LINK_CYC - 1))
        else $error("link rose before hold time");
    flp_sel_a: assert property (I_CLK_EN && r_reg.ctrl[CTL_ANE] && !O_LINK_UP |=> O_FLP_SEL)
        else $error("no link pulses while link down");
    rx_quiet_a: assert property (!O_RX_DV |-> O_RXD == NIB_ZERO)
        else $error("data lines not zero");
    crs_rise_a: assert property ($rose(O_CRS) |-> r_reg.prv == SYM_K && $past(r_reg.prv) == SYM_J)
        else $error("carrier without start pair");
    an_restart_a: assert property ($fell(O_LINK_UP) && $past(r_reg.ctrl[CTL_ANE]) |-> O_AN_RESTART ##1 !O_AN_RESTART)
        else $error("no single restart on link loss");
endmodule  // fep_coding

// file: dv/fep_mac_model.sv
// MAC-side transmit driver for the coding block
module fep_mac_model (
    input  wire logic       i_clk,
    input  wire logic [4:0] i_sym,
    output logic            o_stb,
    output logic            o_en,
    output logic            o_er,
    output logic      [3:0] o_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet transmit side at time zero
    initial begin
        o_stb = 1'b0;
        o_en  = 1'b0;
        o_er  = 1'b0;
        o_txd = 4'h0;
    end
    // One nibble per strobe, held until the taking edge
    // No carrier sense input: gap timing is the MAC's own
    task automatic send(input logic en, er, input logic [3:0] d, output logic [4:0] s);
        @(posedge i_clk);
        o_stb <= 1'b1;
        o_en  <= en;
        o_er  <= er;
        o_txd <= d;
        @(posedge i_clk);
        o_stb <= 1'b0;
        o_txd <= ~d;
        #1 s = i_sym;
    endtask
endmodule // fep_mac_model

// file: dv/tb.sv
// Self-checking bench for the 100 Mbps coding block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fep_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    logic          rx_stb = 1'b0;
    logic          tx_stb, tx_en, tx_er, crs, dv, er, lnk, flp, anr;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic [DW-1:0] rdata;
    logic [4:0]    rx_sym = 5'h1f;
    logic [4:0]    tx_sym, s;
    logic [2:0]    tcnt = 3'h0;
    logic [3:0]    tnib = 4'h0;
    logic [3:0]    txd, rxd;
    int            fail_count = 0;
    int            num_checks = 0;
    int            i, n;
    logic [4:0]    code [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    // Short counts keep the run brief
    fep_coding #(.P_LINK_CYC(64), .P_WIN_CYC(400)) dut (
        .I_CLOCK(clk), .I_RESET_N(rst_n), .I_CLK_EN(1'b1), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WRITE(wr), .I_READ(rd), .O_RDATA(rdata), .I_PHY_ADDR(5'h0b), .I_SPEED_100(1'b1),
        .I_TX_STB(tx_stb), .I_TX_EN(tx_en), .I_TX_ER(tx_er), .I_TXD(txd), .O_TX_SYM(tx_sym),
        .I_RX_STB(rx_stb), .I_RX_SYM(rx_sym), .I_RX_TAIL_CNT(tcnt), .I_RX_TAIL_NIB(tnib),
        .O_RXD(rxd), .O_RX_DV(dv), .O_RX_ER(er), .O_CRS(crs), .O_LINK_UP(lnk),
        .O_FLP_SEL(flp), .O_AN_RESTART(anr));
    fep_mac_model mac (.i_clk(clk), .i_sym(tx_sym), .o_stb(tx_stb), .o_en(tx_en), .o_er(tx_er), .o_txd(txd));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Register write, one strobe cycle
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Register read, data in the following cycle only
    task automatic rreg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("reg", rdata, e);
    endtask
    // One received group; the line is inverted after the strobe
    task automatic rx(input logic [4:0] g, input logic [2:0] c, input logic [3:0] t);
        @(posedge clk);
        rx_stb <= 1'b1;
        rx_sym <= g;
        tcnt <= c;
        tnib <= t;
        @(posedge clk);
        rx_stb <= 1'b0;
        rx_sym <= ~g;
        #1;
    endtask
    // Group plus check of {crs, dv, er, rxd}
    task automatic rxc(input logic [4:0] g, input logic [2:0] c, input logic [3:0] t, input logic [6:0] e);
        rx(g, c, t);
        chk("rx", {crs, dv, er, rxd}, e);
    endtask
    task automatic idles(input int k);
        repeat (k) rx(SYM_IDLE, 3'h0, 4'h0);
    endtask
    task automatic txc(input logic en, er, input logic [3:0] d, input logic [4:0] e);
        mac.send(en, er, d, s);
        chk("tx", s, e);
    endtask
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rreg(REG_CTRL, 16'h0004);
        rreg(REG_STAT, 16'h0000);
        rreg(4'h2, 16'h0000);
        n = 0;
        repeat (4) begin
            mac.send(1'b0, 1'b0, 4'h0, s);
            n += (s !== SYM_IDLE);
        end
        chk("scramble", n != 0, 1);
        wreg(REG_CTRL, 16'h0005);
        rreg(REG_CTRL, 16'h0005);
        idles(14);
        chk("early", lnk, 0);
        rreg(REG_STAT, 16'h0004);
        idles(40);
        chk("link", lnk, 1);
        rreg(REG_STAT, 16'h0006);
        rreg(REG_STAT, 16'h0007);
        // Frame with two trailing bits
        rx(SYM_J, 3'h0, 4'h0);
        rxc(SYM_K, 3'h0, 4'h0, 7'h65);
        rxc(5'h1e, 3'h0, 4'h0, 7'h65);
        rxc(5'h13, 3'h0, 4'h0, 7'h60);
        rxc(SYM_T, 3'h2, 4'h0, 7'h69);
        rxc(SYM_R, 3'h0, 4'h0, 7'h2c);
        rxc(SYM_IDLE, 3'h0, 4'h0, 7'h00);
        idles(14);
        // Invalid group, six trailing bits
        rx(SYM_J, 3'h0, 4'h0);
        rx(SYM_K, 3'h0, 4'h0);
        rxc(5'h00, 3'h0, 4'h0, 7'h65);
        rxc(SYM_T, 3'h6, 4'ha, 7'h70);
        rxc(SYM_R, 3'h0, 4'h0, 7'h2a);
        rxc(SYM_IDLE, 3'h0, 4'h0, 7'h00);
        idles(14);
        // Frame cut short by idle
        rx(SYM_J, 3'h0, 4'h0);
        rx(SYM_K, 3'h0, 4'h0);
        rxc(SYM_IDLE, 3'h0, 4'h0, 7'h10);
        rxc(SYM_IDLE, 3'h0, 4'h0, 7'h00);
        idles(14);
        // Transmit frame with every data code and an error
        txc(1'b1, 1'b0, 4'h5, SYM_J);
        txc(1'b1, 1'b0, 4'h5, SYM_K);
        for (i = 0; i < 16; i++) txc(1'b1, 1'b0, i[3:0], code[i]);
        txc(1'b1, 1'b1, 4'h0, SYM_H);
        txc(1'b0, 1'b0, 4'h0, SYM_T);
        txc(1'b0, 1'b0, 4'h0, SYM_R);
        txc(1'b0, 1'b0, 4'h0, SYM_IDLE);
        idles(14);
        // Line goes quiet: lock and link lost
        n = 0;
        repeat (1000) begin
            @(posedge clk);
            #1 n += (anr === 1'b1);
        end
        chk("link", lnk, 0);
        chk("restart", n, 1);
        chk("pulses", flp, 1);
        rreg(REG_STAT, 16'h0000);
        txc(1'b1, 1'b0, 4'h5, SYM_IDLE);
        txc(1'b0, 1'b0, 4'h0, SYM_IDLE);
        wreg(REG_CTRL, 16'h0003);
        @(posedge clk);
        #1 chk("pulses", flp, 0);
        txc(1'b1, 1'b0, 4'h5, SYM_J);
        txc(1'b1, 1'b0, 4'h5, SYM_K);
        txc(1'b0, 1'b0, 4'h0, SYM_T);
        txc(1'b0, 1'b0, 4'h0, SYM_R);
        print_verdict();
    end
endmodule // tb
